/* logic/pms_cfg.svh */
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH
`define PMS_CLK_MHZ 200
`define PMS_WDOG_MS 100
`define PMS_WDOG_CYC (`PMS_WDOG_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_CYC_LIMIT_MIN_MS 1
`define PMS_CYC_LIMIT_MIN_CYC (`PMS_CYC_LIMIT_MIN_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_GESTURE_MS 3000
`define PMS_GESTURE_CYC (`PMS_GESTURE_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_DEBOUNCE_US 10000
`define PMS_DEBOUNCE_CYC (`PMS_DEBOUNCE_US * `PMS_CLK_MHZ)
`define PMS_BLINK_MS 250
`define PMS_BLINK_CYC (`PMS_BLINK_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_STATION_DEFAULT 8'h02
`define PMS_AO_SAFE_V 16'h0000
`define PMS_AO_SAFE_0MA 16'h0000
`define PMS_AO_SAFE_4MA 16'h1999
`define PMS_PKG_PFX0 8'h70
`define PMS_PKG_PFX1 8'h78
`define PMS_ASCII_0 8'h30
`define PMS_ASCII_9 8'h39
`endif

/* logic/pms_pkg.sv */
package pms_pkg;
   typedef enum logic [1:0] {
      PMS_AO_VOLT,
      PMS_AO_I020,
      PMS_AO_I420
   } pms_ao_kind_e;
   typedef enum {
      PMS_ST_STOP,
      PMS_ST_CLR_IN,
      PMS_ST_START_RD,
      PMS_ST_STARTUP,
      PMS_ST_CLR_OUT,
      PMS_ST_READ_IN,
      PMS_ST_CYCLIC,
      PMS_ST_WRITE_OUT,
      PMS_ST_ERASE,
      PMS_ST_RELOAD
   } pms_state_e;
   typedef enum {
      PMS_G_IDLE,
      PMS_G_HOLD,
      PMS_G_ARMED,
      PMS_G_TAP
   } pms_gesture_e;
endpackage

/* logic/pms_switch_in.sv */
`timescale 1ns/100ps
`include "pms_cfg.svh"
// Two-flop synchroniser followed by a stability filter for one switch contact.
module pms_switch_in
   import pms_pkg::*;
#(
   parameter int unsigned STABLE_CYC = `PMS_DEBOUNCE_CYC
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic raw,
   output logic      clean
);
   initial begin
      if (STABLE_CYC < 1) $error("STABLE_CYC must be at least one");
   end
   logic        meta_r;
   logic        sync_r;
   logic        last_r;
   logic [31:0] cnt_r;
   logic        settled;
   assign settled = (cnt_r >= STABLE_CYC[31:0]);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= raw;
         sync_r <= meta_r;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         last_r <= 1'b0;
         cnt_r  <= 32'h0;
         clean  <= 1'b0;
      end else begin
         last_r <= sync_r;
         if (sync_r != last_r) begin
            cnt_r <= 32'h0;
         end else if (!settled) begin
            cnt_r <= cnt_r + 32'h1;
         end else begin
            clean <= sync_r;
         end
      end
   end
endmodule

/* logic/pms_pkg_name.sv */
`timescale 1ns/100ps
`include "pms_cfg.svh"
// Checks an eight-character file stem: prefix px followed by six decimal digits.
module pms_pkg_name
   import pms_pkg::*;
(
   input  wire logic [63:0] name,
   output logic             match
);
   logic [7:0] digit_ok;
   genvar i;
   generate
      for (i = 0; i < 6; i++) begin : g_dig
         assign digit_ok[i] = (name[i*8 +: 8] >= `PMS_ASCII_0) && (name[i*8 +: 8] <= `PMS_ASCII_9);
      end
   endgenerate
   assign digit_ok[6] = (name[55:48] == `PMS_PKG_PFX1);
   assign digit_ok[7] = (name[63:56] == `PMS_PKG_PFX0);
   assign match = &digit_ok;
endmodule

/* logic/pms_supervisor.sv */
`timescale 1ns/100ps
`include "pms_cfg.svh"
// Notes on behaviour
// - Fixed 100 ms watchdog resets into STOP.
// - Configurable cycle limit, minimum 1 ms, forces STOP.
// - RUN to STOP sets inhibit, disables digital outputs.
// - STOP drives analog outputs to safe or substitute.
// - Remote outputs follow local inhibit and safe values.
// - Remote inputs keep being read while stopped.
// - Start: clear inputs, startup routine, release, cycle.
// - Remote inputs read once during start-up.
// - RUN cycle: read inputs, cyclic routine, write outputs.
// - Overall reset erases internal memory, not card.
// - Hold reset position 3 s in STOP arms.
// - Armed short tap starts reset; indicator flashes.
// - Remote overall reset accepted only in STOP.
// - Reload project after reset; card indicator lit.
// - After reload, mode follows switch position.
// - Factory reset clears RAM, station address two.
// - Power-on STOP finds differing package, waits request.
// - Same package version skips the update.
// - Package name is px plus six digits.
// - STOP halts program, keeps data, outputs disabled.
module pms_supervisor
   import pms_pkg::*;
#(
   parameter int unsigned WDOG_CYC    = `PMS_WDOG_CYC,
   parameter int unsigned GESTURE_CYC = `PMS_GESTURE_CYC,
   parameter int unsigned DEBOUNCE_CYC = `PMS_DEBOUNCE_CYC,
   parameter int unsigned BLINK_CYC   = `PMS_BLINK_CYC,
   parameter int unsigned N_AO        = 4,
   parameter int unsigned AO_W        = 16
) (
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   sw_run,
   input  wire logic                   sw_mres,
   input  wire logic                   wdog_kick,
   input  wire logic [31:0]            cycle_limit_cyc,
   input  wire logic                   startup_done,
   input  wire logic                   cyclic_done,
   input  wire logic                   image_op_done,
   input  wire logic                   remote_rd_done,
   input  wire logic                   prog_mres_req,
   input  wire logic                   factory_req,
   input  wire logic                   erase_done,
   input  wire logic                   card_has_reload,
   input  wire logic                   reload_done,
   input  wire logic                   card_pkg_found,
   input  wire logic [63:0]            card_pkg_name,
   input  wire logic [31:0]            card_pkg_ver,
   input  wire logic [31:0]            fw_ver,
   input  wire logic                   update_req,
   input  wire logic [N_AO*2-1:0]      ao_kind,
   input  wire logic [N_AO-1:0]        ao_subst_en,
   input  wire logic [N_AO*AO_W-1:0]   ao_subst_val,
   input  wire logic [N_AO*AO_W-1:0]   ao_run_val,
   output logic                        output_inhibit,
   output logic                        do_enable,
   output logic                        remote_out_enable,
   output logic [N_AO*AO_W-1:0]        ao_out,
   output logic [N_AO*AO_W-1:0]        remote_ao_out,
   output logic                        clr_input_image,
   output logic                        clr_output_image,
   output logic                        read_input_image,
   output logic                        write_output_image,
   output logic                        run_startup_routine,
   output logic                        run_cyclic_routine,
   output logic                        remote_in_read,
   output logic                        erase_user_mem,
   output logic                        card_reload_go,
   output logic                        card_indicator,
   output logic                        stop_indicator,
   output logic                        run_indicator,
   output logic                        fw_update_pending,
   output logic                        fw_update_go,
   output logic [7:0]                  station_addr,
   output logic                        in_stop,
   output logic                        wdog_fired,
   output logic                        cycle_overrun
);
   initial begin
      if (N_AO < 1 || AO_W < 16) $error("N_AO must be positive and AO_W at least 16");
      if (WDOG_CYC < 1 || GESTURE_CYC < 1 || BLINK_CYC < 1) $error("timing counts must be positive");
   end

   logic run_pos;
   logic mres_pos;
   pms_switch_in #(.STABLE_CYC(DEBOUNCE_CYC)) u_sw_run (
      .mclk  (mclk),
      .rst   (rst),
      .raw   (sw_run),
      .clean (run_pos)
   );
   pms_switch_in #(.STABLE_CYC(DEBOUNCE_CYC)) u_sw_mres (
      .mclk  (mclk),
      .rst   (rst),
      .raw   (sw_mres),
      .clean (mres_pos)
   );
   logic name_ok;
   pms_pkg_name u_name (
      .name  (card_pkg_name),
      .match (name_ok)
   );

   pms_state_e   st_r, st_nxt;
   pms_gesture_e g_r, g_nxt;
   logic [31:0]  wd_r, cyc_r, g_cnt_r, blink_cnt_r;
   logic         blink_r, factory_r, por_r, fw_check_r, erasing_r;
   logic [31:0]  limit_eff;

   // The cycle limit is clamped so software cannot configure a limit below 1 ms.
   assign limit_eff = (cycle_limit_cyc < `PMS_CYC_LIMIT_MIN_CYC) ? `PMS_CYC_LIMIT_MIN_CYC : cycle_limit_cyc;

   wire running   = (st_r == PMS_ST_CLR_OUT) || (st_r == PMS_ST_READ_IN) ||
                    (st_r == PMS_ST_CYCLIC) || (st_r == PMS_ST_WRITE_OUT);
   wire wd_trip   = running && (wd_r >= WDOG_CYC - 1);
   wire cyc_trip  = running && (cyc_r >= limit_eff - 32'h1);
   wire fault     = wd_trip || cyc_trip;
   wire g_expired = (g_cnt_r >= GESTURE_CYC - 1);
   wire sw_mres_go = (g_r == PMS_G_TAP) && !mres_pos && !g_expired;
   wire prog_go   = prog_mres_req && (st_r == PMS_ST_STOP);
   wire mres_go   = (st_r == PMS_ST_STOP) && (sw_mres_go || prog_go || factory_req);
   wire start_go  = (st_r == PMS_ST_STOP) && run_pos && !fw_update_pending && !mres_go;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         PMS_ST_STOP:      if (mres_go) st_nxt = PMS_ST_ERASE;
                           else if (start_go) st_nxt = PMS_ST_CLR_IN;
         PMS_ST_CLR_IN:    st_nxt = PMS_ST_START_RD;
         PMS_ST_START_RD:  if (remote_rd_done) st_nxt = PMS_ST_STARTUP;
         PMS_ST_STARTUP:   if (startup_done) st_nxt = PMS_ST_CLR_OUT;
         PMS_ST_CLR_OUT:   st_nxt = PMS_ST_READ_IN;
         PMS_ST_READ_IN:   if (image_op_done) st_nxt = PMS_ST_CYCLIC;
         PMS_ST_CYCLIC:    if (cyclic_done) st_nxt = PMS_ST_WRITE_OUT;
         PMS_ST_WRITE_OUT: if (image_op_done) st_nxt = run_pos ? PMS_ST_READ_IN : PMS_ST_STOP;
         PMS_ST_ERASE:     if (erase_done) st_nxt = card_has_reload && !factory_r ? PMS_ST_RELOAD : PMS_ST_STOP;
         PMS_ST_RELOAD:    if (reload_done) st_nxt = run_pos ? PMS_ST_CLR_IN : PMS_ST_STOP;
         default:          st_nxt = PMS_ST_STOP;
      endcase
      if (fault) st_nxt = PMS_ST_STOP;
   end

   always_comb begin
      g_nxt = g_r;
      case (g_r)
         PMS_G_IDLE:  if (st_r == PMS_ST_STOP && mres_pos) g_nxt = PMS_G_HOLD;
         PMS_G_HOLD:  if (!mres_pos) g_nxt = PMS_G_IDLE;
                      else if (g_expired) g_nxt = PMS_G_ARMED;
         PMS_G_ARMED: if (mres_pos && g_cnt_r == 32'h0) g_nxt = PMS_G_TAP;
         PMS_G_TAP:   if (!mres_pos || g_expired) g_nxt = PMS_G_IDLE;
         default:     g_nxt = PMS_G_IDLE;
      endcase
      if (st_r != PMS_ST_STOP) g_nxt = PMS_G_IDLE;
   end

   // ARMED waits for the switch to leave the reset position before a tap counts.
   wire g_count_clr = (g_nxt != g_r) || (g_r == PMS_G_ARMED && !mres_pos);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r    <= PMS_ST_STOP;
         g_r     <= PMS_G_IDLE;
         g_cnt_r <= 32'h0;
      end else begin
         st_r    <= st_nxt;
         g_r     <= g_nxt;
         // Entering ARMED with the switch still held must not count as a tap, so the counter reads one there.
         g_cnt_r <= (g_nxt == PMS_G_ARMED && mres_pos) ? 32'h1 : g_count_clr ? 32'h0 : g_cnt_r + 32'h1;
      end
   end

   // The watchdog is retriggered by each kick; the cycle monitor restarts at each write of the outputs.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wd_r  <= 32'h0;
         cyc_r <= 32'h0;
      end else begin
         wd_r  <= (!running || wdog_kick) ? 32'h0 : wd_r + 32'h1;
         cyc_r <= (!running || st_r == PMS_ST_WRITE_OUT) ? 32'h0 : cyc_r + 32'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wdog_fired    <= 1'b0;
         cycle_overrun <= 1'b0;
         factory_r     <= 1'b0;
         station_addr  <= `PMS_STATION_DEFAULT;
         erasing_r     <= 1'b0;
      end else begin
         if (start_go) begin
            wdog_fired    <= 1'b0;
            cycle_overrun <= 1'b0;
         end
         if (wd_trip) wdog_fired <= 1'b1;
         if (cyc_trip) cycle_overrun <= 1'b1;
         if (mres_go) factory_r <= factory_req;
         if (st_r == PMS_ST_ERASE && erase_done && factory_r) station_addr <= `PMS_STATION_DEFAULT;
         erasing_r <= (st_nxt == PMS_ST_ERASE);
      end
   end

   // Firmware check happens once, on the first STOP after power-on.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         por_r             <= 1'b1;
         fw_check_r        <= 1'b0;
         fw_update_pending <= 1'b0;
         fw_update_go      <= 1'b0;
      end else begin
         por_r        <= 1'b0;
         fw_check_r   <= por_r;
         fw_update_go <= 1'b0;
         if (fw_check_r && st_r == PMS_ST_STOP && card_pkg_found && name_ok &&
             card_pkg_ver != fw_ver) fw_update_pending <= 1'b1;
         if (fw_update_pending && update_req && st_r == PMS_ST_STOP) begin
            fw_update_go      <= 1'b1;
            fw_update_pending <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         blink_cnt_r <= 32'h0;
         blink_r     <= 1'b0;
      end else begin
         blink_cnt_r <= (blink_cnt_r >= BLINK_CYC - 1) ? 32'h0 : blink_cnt_r + 32'h1;
         if (blink_cnt_r >= BLINK_CYC - 1) blink_r <= !blink_r;
      end
   end

   wire outputs_live = running && !fault;
   logic [N_AO*AO_W-1:0] ao_safe;
   genvar k;
   generate
      for (k = 0; k < N_AO; k++) begin : g_ao
         wire [AO_W-1:0] base = (ao_kind[k*2 +: 2] == 2'(PMS_AO_I420)) ? AO_W'(`PMS_AO_SAFE_4MA) :
                                (ao_kind[k*2 +: 2] == 2'(PMS_AO_I020)) ? AO_W'(`PMS_AO_SAFE_0MA) :
                                AO_W'(`PMS_AO_SAFE_V);
         assign ao_safe[k*AO_W +: AO_W] = ao_subst_en[k] ? ao_subst_val[k*AO_W +: AO_W] : base;
      end
   endgenerate

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         output_inhibit    <= 1'b1;
         do_enable         <= 1'b0;
         remote_out_enable <= 1'b0;
         ao_out            <= '0;
         remote_ao_out     <= '0;
      end else begin
         output_inhibit    <= !outputs_live;
         do_enable         <= outputs_live;
         remote_out_enable <= outputs_live;
         ao_out            <= outputs_live ? ao_run_val : ao_safe;
         remote_ao_out     <= outputs_live ? ao_run_val : ao_safe;
      end
   end

   // Remote input polling continues while stopped so the latest values stay available.
   wire stop_poll = (st_r == PMS_ST_STOP) && blink_cnt_r == 32'h0;
   assign remote_in_read      = stop_poll || (st_r == PMS_ST_START_RD) || (st_r == PMS_ST_READ_IN);
   assign clr_input_image     = (st_r == PMS_ST_CLR_IN);
   assign clr_output_image    = (st_r == PMS_ST_CLR_OUT);
   assign read_input_image    = (st_r == PMS_ST_READ_IN);
   assign write_output_image  = (st_r == PMS_ST_WRITE_OUT);
   assign run_startup_routine = (st_r == PMS_ST_STARTUP);
   assign run_cyclic_routine  = (st_r == PMS_ST_CYCLIC);
   assign erase_user_mem      = erasing_r;
   assign card_reload_go      = (st_r == PMS_ST_RELOAD);
   assign card_indicator      = (st_r == PMS_ST_RELOAD) || fw_update_go;
   assign in_stop             = (st_r == PMS_ST_STOP);
   assign run_indicator       = running;
   assign stop_indicator      = (st_r == PMS_ST_ERASE) ? blink_r :
                                (g_r == PMS_G_HOLD) ? blink_r :
                                fw_update_pending ? blink_r :
                                (st_r == PMS_ST_STOP);

   wathdog_a: assert property (@(posedge mclk) disable iff (rst)
      wd_trip |=> st_r == PMS_ST_STOP && output_inhibit && wdog_fired) else $error("watchdog did not stop");
   cyc_limit_a: assert property (@(posedge mclk) disable iff (rst)
      cyc_trip |-> cyc_r >= `PMS_CYC_LIMIT_MIN_CYC - 1) else $error("cycle limit below minimum");
   inhibit_stop_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(running) |=> output_inhibit && !do_enable && !remote_out_enable) else $error("outputs live in stop");
   safe_ao_a: assert property (@(posedge mclk) disable iff (rst)
      (st_r == PMS_ST_STOP) |=> ao_out == $past(ao_safe)) else $error("analog not safe in stop");
   start_order_a: assert property (@(posedge mclk) disable iff (rst)
      start_go |=> clr_input_image ##1 (st_r == PMS_ST_START_RD)) else $error("start order wrong");
   run_seq_a: assert property (@(posedge mclk) disable iff (rst)
      (read_input_image && image_op_done && !fault) |=> run_cyclic_routine) else $error("cycle order wrong");
   prog_mres_a: assert property (@(posedge mclk) disable iff (rst)
      (prog_mres_req && st_r != PMS_ST_STOP && !factory_req) |=> st_r != PMS_ST_ERASE) else $error("reset outside stop");
   reload_led_a: assert property (@(posedge mclk) disable iff (rst)
      card_reload_go |-> card_indicator) else $error("card indicator off in reload");
   fw_same_a: assert property (@(posedge mclk) disable iff (rst)
      (fw_check_r && card_pkg_ver == fw_ver && !fw_update_pending) |=> !fw_update_pending) else $error("same version pending");
   c_run: cover property (@(posedge mclk) disable iff (rst) write_output_image ##1 read_input_image);
   c_mres: cover property (@(posedge mclk) disable iff (rst) sw_mres_go);
   c_wdog: cover property (@(posedge mclk) disable iff (rst) wd_trip);
   c_reload: cover property (@(posedge mclk) disable iff (rst) card_reload_go ##1 in_stop);
endmodule

/* tb/pms_far_model.sv */
`timescale 1ns/100ps
// Far-side stand-in: answers each step strobe once, lat cycles after it settles.
// A strobe shorter than lat+2 cycles is never answered, as a slow real party would do.
module pms_far_model (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [3:0] lat,
   input  wire logic       kick_en,
   input  wire logic       read_input_image,
   input  wire logic       write_output_image,
   input  wire logic       run_startup_routine,
   input  wire logic       run_cyclic_routine,
   input  wire logic       remote_in_read,
   input  wire logic       erase_user_mem,
   input  wire logic       card_reload_go,
   output logic            image_op_done,
   output logic            startup_done,
   output logic            cyclic_done,
   output logic            remote_rd_done,
   output logic            erase_done,
   output logic            reload_done,
   output logic            wdog_kick
);
   logic [6:0] req;
   logic [6:0] req_q;
   logic [6:0] dn;
   logic [4:0] cnt;
   logic [5:0] kcnt;
   assign req = {card_reload_go, erase_user_mem, remote_in_read, run_cyclic_routine, run_startup_routine,
                 write_output_image, read_input_image};
   assign image_op_done = dn[0] | dn[1];
   assign startup_done = dn[2];
   assign cyclic_done = dn[3];
   assign remote_rd_done = dn[4];
   assign erase_done = dn[5];
   assign reload_done = dn[6];
   always @(negedge mclk or posedge rst) begin
      if (rst) begin
         req_q <= 7'h00;
         dn <= 7'h00;
         cnt <= 5'h00;
         kcnt <= 6'h00;
         wdog_kick <= 1'b0;
      end else begin
         req_q <= req;
         cnt <= (req != req_q) ? 5'h00 : (cnt <= {1'b0, lat}) ? cnt + 5'h01 : cnt;
         dn <= (req == req_q && cnt == {1'b0, lat}) ? req : 7'h00;
         kcnt <= kcnt + 6'h01;
         wdog_kick <= kick_en && kcnt == 6'h3F;
      end
   end
endmodule

/* tb/pms_supervisor_test.sv */
`timescale 1ns/100ps
`include "pms_cfg.svh"
module pms_supervisor_test;
   import pms_pkg::*;
   typedef struct {int id; logic [63:0] v;} pms_note_s;
   logic mclk, rst, sw_run, sw_mres, prog_mres_req, factory_req, update_req, card_has_reload, card_pkg_found;
   logic kick_en, track, wdog_kick, startup_done, cyclic_done, image_op_done, remote_rd_done, erase_done;
   logic reload_done, output_inhibit, do_enable, remote_out_enable, clr_input_image, clr_output_image;
   logic read_input_image, write_output_image, run_startup_routine, run_cyclic_routine, remote_in_read;
   logic erase_user_mem, card_reload_go, card_indicator, stop_indicator, fw_update_pending, fw_update_go;
   logic in_stop, wdog_fired, run_ind, overrun;
   logic [3:0] lat, ao_subst_en, seen_r;
   logic [7:0] ao_kind, station_addr;
   logic [31:0] card_pkg_ver, fw_ver;
   logic [63:0] card_pkg_name, ao_subst_val, ao_run_val, ao_out, remote_ao_out, safe;
   logic [6:0] s, s_q;
   logic [14:0] fl;
   int n_mismatch, compares, tcount;
   int step_q[$];
   pms_note_s val_q[$];
   string nm[15] = '{"inhibit", "do_enable", "remote_out_enable", "ao_out", "remote_ao_out", "station_addr",
      "in_stop", "stop_indicator", "card_indicator", "fw_update_pending", "wdog_fired", "erase_seen",
      "update_go_seen", "remote_read_seen", "reload_go_seen"};
   pms_supervisor #(.WDOG_CYC(200), .GESTURE_CYC(50), .DEBOUNCE_CYC(2), .BLINK_CYC(4)) pms_supervisor_inst (
      .mclk(mclk), .rst(rst), .sw_run(sw_run), .sw_mres(sw_mres), .wdog_kick(wdog_kick),
      .cycle_limit_cyc(32'h00030D40), .startup_done(startup_done), .cyclic_done(cyclic_done),
      .image_op_done(image_op_done), .remote_rd_done(remote_rd_done), .prog_mres_req(prog_mres_req),
      .factory_req(factory_req), .erase_done(erase_done), .card_has_reload(card_has_reload),
      .reload_done(reload_done), .card_pkg_found(card_pkg_found), .card_pkg_name(card_pkg_name),
      .card_pkg_ver(card_pkg_ver), .fw_ver(fw_ver), .update_req(update_req), .ao_kind(ao_kind),
      .ao_subst_en(ao_subst_en), .ao_subst_val(ao_subst_val), .ao_run_val(ao_run_val),
      .output_inhibit(output_inhibit), .do_enable(do_enable), .remote_out_enable(remote_out_enable),
      .ao_out(ao_out), .remote_ao_out(remote_ao_out), .clr_input_image(clr_input_image),
      .clr_output_image(clr_output_image), .read_input_image(read_input_image),
      .write_output_image(write_output_image), .run_startup_routine(run_startup_routine),
      .run_cyclic_routine(run_cyclic_routine), .remote_in_read(remote_in_read), .erase_user_mem(erase_user_mem),
      .card_reload_go(card_reload_go), .card_indicator(card_indicator), .stop_indicator(stop_indicator),
      .run_indicator(run_ind), .fw_update_pending(fw_update_pending), .fw_update_go(fw_update_go),
      .station_addr(station_addr), .in_stop(in_stop), .wdog_fired(wdog_fired), .cycle_overrun(overrun));
   pms_far_model pms_far_model_inst (
      .mclk(mclk), .rst(rst), .lat(lat), .kick_en(kick_en), .read_input_image(read_input_image),
      .write_output_image(write_output_image), .run_startup_routine(run_startup_routine),
      .run_cyclic_routine(run_cyclic_routine), .remote_in_read(remote_in_read), .erase_user_mem(erase_user_mem),
      .card_reload_go(card_reload_go), .image_op_done(image_op_done), .startup_done(startup_done),
      .cyclic_done(cyclic_done), .remote_rd_done(remote_rd_done), .erase_done(erase_done),
      .reload_done(reload_done), .wdog_kick(wdog_kick));
   assign s = {clr_input_image, remote_in_read, run_startup_routine, clr_output_image, read_input_image,
               run_cyclic_routine, write_output_image};
   assign fl = {seen_r, wdog_fired, fw_update_pending, card_indicator, stop_indicator, in_stop, 3'b000,
                remote_out_enable, do_enable, output_inhibit};
   function automatic logic [63:0] probe(input int id);
      probe = (id == 3) ? ao_out : (id == 4) ? remote_ao_out : (id == 5) ? {56'h0, station_addr} : {63'h0, fl[id]};
   endfunction
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      if (n_mismatch == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic note(input int id, input logic [63:0] v);
      val_q.push_back('{id, v});
   endtask
   task automatic await(input int id, input logic [63:0] v, input int lim);
      for (int i = 0; i < lim && probe(id) !== v; i++)
         cyc(1);
      note(id, v);
   endtask
   task automatic clr_seen;
      @(posedge mclk);
      seen_r = 4'h0;
      @(negedge mclk);
   endtask
   task automatic rst_dut;
      rst = 1'b1;
      cyc(6);
      rst = 1'b0;
      cyc(2);
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Results are compared in order of appearance, in the driver's own time step once it next waits.
   initial forever begin
      pms_note_s n;
      wait (val_q.size() != 0);
      n = val_q.pop_front();
      check(nm[n.id], probe(n.id), n.v);
   end
   always @(negedge mclk) begin
      s_q <= s;
      seen_r <= seen_r | {card_reload_go, remote_in_read, fw_update_go, erase_user_mem};
      for (int k = 6; k >= 0; k--)
         // Reading the input image also polls the remote inputs; that poll is not a step of its own.
         if (track && !in_stop && s[k] && !s_q[k] && !(k == 5 && s[2]))
            check("step", 64'(7 - k), 64'(step_q.size() ? step_q.pop_front() : 0));
   end
   always @(posedge mclk) begin
      tcount++;
      if (tcount == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      void'($urandom(32'h4E56941C));
      {sw_run, sw_mres, prog_mres_req, factory_req, update_req, card_has_reload, card_pkg_found} = 7'h00;
      track = 1'b0;
      seen_r = 4'h0;
      s_q = 7'h00;
      kick_en = 1'b1;
      rst = 1'b1;
      lat = 4'($urandom_range(3, 0));
      ao_kind = {PMS_AO_I420, PMS_AO_I420, PMS_AO_I020, PMS_AO_VOLT};
      ao_subst_en = 4'h8;
      ao_subst_val = {$urandom, $urandom};
      ao_run_val = {$urandom, $urandom};
      fw_ver = 32'h00030600;
      card_pkg_ver = fw_ver;
      card_pkg_name = "px000123";
      safe = {ao_subst_val[63:48], `PMS_AO_SAFE_4MA, `PMS_AO_SAFE_0MA, `PMS_AO_SAFE_V};
      rst_dut();
      note(0, 1);
      note(1, 0);
      note(5, 2);
      note(3, safe);
      note(4, safe);
      clr_seen();
      cyc(40);
      note(13, 1);
      track = 1'b1;
      step_q = '{1, 2, 3, 4, 5, 6, 7, 5, 6, 7};
      sw_run = 1'b1;
      for (int i = 0; i < 600 && step_q.size() != 0; i++)
         cyc(1);
      track = 1'b0;
      check("steps_left", 64'(step_q.size()), 0);
      cyc(4);
      note(0, 0);
      note(1, 1);
      note(3, ao_run_val);
      check("run_indicator", {63'h0, run_ind}, 1);
      check("cycle_overrun", {63'h0, overrun}, 0);
      clr_seen();
      prog_mres_req = 1'b1;
      cyc(1);
      prog_mres_req = 1'b0;
      cyc(10);
      note(11, 0);
      note(6, 0);
      sw_run = 1'b0;
      await(6, 1, 100);
      cyc(3);
      note(0, 1);
      note(1, 0);
      note(2, 0);
      note(3, safe);
      note(4, safe);
      check("run_indicator", {63'h0, run_ind}, 0);
      sw_run = 1'b1;
      await(6, 0, 100);
      cyc(20);
      kick_en = 1'b0;
      await(10, 1, 400);
      note(6, 1);
      note(0, 1);
      sw_run = 1'b0;
      kick_en = 1'b1;
      rst_dut();
      sw_mres = 1'b1;
      cyc(80);
      for (int i = 0; i < 8; i++) begin
         note(7, 1);
         cyc(1);
      end
      sw_mres = 1'b0;
      cyc(10);
      clr_seen();
      sw_mres = 1'b1;
      cyc(10);
      sw_mres = 1'b0;
      await(11, 1, 60);
      cyc(40);
      note(7, 1);
      card_has_reload = 1'b1;
      lat = 4'h6;
      clr_seen();
      prog_mres_req = 1'b1;
      cyc(1);
      prog_mres_req = 1'b0;
      await(11, 1, 30);
      await(14, 1, 60);
      note(8, 1);
      await(8, 0, 60);
      note(6, 1);
      clr_seen();
      factory_req = 1'b1;
      cyc(1);
      factory_req = 1'b0;
      await(11, 1, 30);
      cyc(30);
      note(5, 2);
      for (int i = 0; i < 3; i++) begin
         card_pkg_found = 1'b1;
         card_pkg_name = (i == 2) ? "py000123" : "px000123";
         card_pkg_ver = (i == 1) ? fw_ver : fw_ver + 32'h1;
         rst_dut();
         cyc(20);
         note(9, {63'h0, i == 0});
         clr_seen();
         update_req = 1'b1;
         cyc(1);
         update_req = 1'b0;
         cyc(10);
         note(12, {63'h0, i == 0});
      end
      sw_run = 1'b1;
      cyc(1);
      sw_run = 1'b0;
      cyc(10);
      note(6, 1);
      cyc(2);
      conclude();
   end
endmodule
